//--- rtl/adc_seq_pkg.sv
// Purpose: Shared constants for the converter sequencer and power control
// Assumes: core_clk at 100 MHz
// Notes: Control word bit positions, mode codes and timing counts
package adc_seq_pkg;
    localparam int CTRL_W = 12;
    localparam int XFER_W = 16;
    localparam int DATA_W = 12;
    localparam int CH_W = 3;
    localparam int NUM_CH = 8;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] XFER_CLKS = 5'h10;
    localparam logic [CNT_W-1:0] LAST_SHIFT = 5'h0f;
    localparam logic [CNT_W-1:0] TRACK_FALL = 5'h0d;
    localparam int WRITE_POS = 11;
    localparam int SEQ_POS = 10;
    localparam int ADDR_MSB = 9;
    localparam int ADDR_LSB = 7;
    localparam int PM_HI_POS = 6;
    localparam int PM_LO_POS = 5;
    localparam int SHADOW_POS = 4;
    localparam int RANGE_POS = 1;
    localparam int CODING_POS = 0;
    localparam int MASK_LSB = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h060;
    localparam logic [NUM_CH-1:0] MASK_RESET = 8'h00;
    localparam logic [1:0] PM_NORMAL = 2'h3;
    localparam logic [1:0] PM_FULL = 2'h2;
    localparam logic [1:0] PM_AUTO = 2'h1;
    localparam logic [1:0] SQ_KEEP = 2'h2;
    localparam logic [1:0] SQ_SHADOW = 2'h1;
    localparam logic [1:0] SQ_CONSEC = 2'h3;
    localparam logic [CH_W-1:0] CH_ZERO = 3'h0;
    localparam logic [CH_W-1:0] CH_TOP = 3'h7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_INTERVAL_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {
        SEQ_OFF = 2'b00,
        SEQ_MASK = 2'b01,
        SEQ_CONSEC = 2'b10
    } seq_mode_t;
endpackage : adc_seq_pkg

//--- rtl/adc_seq_ctrl.sv
// Purpose: Sequencer, control word, result word and power control of an eight-input converter
// Assumes: cs_n, sclk and din come from an outside host; adc_data is on core_clk
// Notes: Serial pins are synchronised and their edges found on core_clk
// Function
// - Address field selects converted input channel
// - Mask sequencing converts flagged channels ascending
// - After highest flagged channel, wrap to lowest
// - Write bit low leaves control word unchanged
// - Only sequence bits 1,0 keep sequence running
// - Bits 1,1 convert channel zero up to address
// - Consecutive sequence restarts at zero after last
// - Word is zero, channel, twelve result bits
// - Range bit selects single or double span
// - Chip select fall starts conversion, holds sample
// - First twelve bits load control word
// - After shadow request, low eight of sixteen bits load mask
// - Both power bits one keep device powered
// - Sixteen clocks; track again on fourteenth fall, except when loading mask
// - Power bits 1,0 shut down, keep control
// - Wake from shutdown starts at chip select rise
// - Wake transfer needs sixteen clocks, output undriven
// - Power bits 0,1 sleep after each conversion
// - Early chip select rise aborts, control unchanged
// - Lowest control bit selects two's complement coding
// - Output released on sixteenth falling clock edge
`timescale 1ns/1ps

module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count != FULL_CNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : result_fifo

module adc_seq_ctrl #(
    parameter int WAKE_CYC = adc_seq_pkg::WAKE_CYCLES,
    parameter int DEPTH = adc_seq_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic [11:0] adc_data,
    output logic dout,
    output logic dout_oe,
    output logic [2:0] channel_sel,
    output logic sample_hold,
    output logic conv_start,
    output logic span_double,
    output logic coding_twos,
    output logic powered_down,
    output logic waking,
    output logic [15:0] result_word,
    output logic result_valid,
    input wire logic result_ready,
    output logic result_overrun
);
    function automatic logic [2:0] next_flag(input logic [7:0] m, input logic [2:0] cur);
        logic [2:0] c;
        logic found;
        c = cur;
        found = 1'b0;
        next_flag = cur;
        for (int k = 1; k <= 8; k++) begin
            c = cur + 3'(k);
            if (m[c] && !found) begin
                next_flag = c;
                found = 1'b1;
            end
        end
    endfunction : next_flag

    logic [2:0] cs_s;
    logic [2:0] sclk_s;
    logic [1:0] din_s;
    logic in_xfer;
    logic [4:0] fall_cnt;
    logic [4:0] rise_cnt;
    logic [15:0] rx_sr;
    logic [15:0] tx_sr;
    logic [15:0] cap_word;
    logic [11:0] ctrl;
    logic [7:0] mask;
    logic [2:0] ptr;
    logic [2:0] last_ch;
    adc_seq_pkg::seq_mode_t mode;
    logic shadow_load;
    logic wake_xfer;
    logic [15:0] wake_cnt;
    logic pend;
    logic [15:0] pend_word;
    logic fifo_ready;

    wire cs_fall = cs_s[2] & ~cs_s[1];
    wire cs_rise = ~cs_s[2] & cs_s[1];
    wire sclk_fall = in_xfer & sclk_s[2] & ~sclk_s[1];
    wire sclk_rise = in_xfer & ~sclk_s[2] & sclk_s[1];
    wire full_len = (fall_cnt == adc_seq_pkg::XFER_CLKS) & (rise_cnt == adc_seq_pkg::XFER_CLKS);
    wire complete = cs_rise & in_xfer & full_len;
    wire abort = cs_rise & in_xfer & ~full_len;
    wire [11:0] rx_ctl = rx_sr[15:4];
    wire [7:0] rx_mask = rx_sr[adc_seq_pkg::MASK_LSB +: 8];
    wire mask_wr = complete & shadow_load;
    wire ctl_wr = complete & ~shadow_load & rx_ctl[adc_seq_pkg::WRITE_POS];
    wire [1:0] rx_sq = {rx_ctl[adc_seq_pkg::SEQ_POS], rx_ctl[adc_seq_pkg::SHADOW_POS]};
    wire [2:0] rx_addr = rx_ctl[adc_seq_pkg::ADDR_MSB:adc_seq_pkg::ADDR_LSB];
    wire [1:0] pm = {ctrl[adc_seq_pkg::PM_HI_POS], ctrl[adc_seq_pkg::PM_LO_POS]};
    wire [1:0] new_pm = ctl_wr ? {rx_ctl[adc_seq_pkg::PM_HI_POS], rx_ctl[adc_seq_pkg::PM_LO_POS]} : pm;
    wire [2:0] addr = ctrl[adc_seq_pkg::ADDR_MSB:adc_seq_pkg::ADDR_LSB];
    wire [2:0] conv_ch = (mode == adc_seq_pkg::SEQ_OFF) ? addr : ptr;
    wire [2:0] next_ptr = (mode == adc_seq_pkg::SEQ_MASK) ? next_flag(mask, ptr) :
        ((ptr == last_ch) ? adc_seq_pkg::CH_ZERO : ptr + 3'h1);
    wire [11:0] coded = coding_twos ? {~adc_data[11], adc_data[10:0]} : adc_data;
    wire [15:0] new_word = {1'b0, conv_ch, coded};
    wire go_down = (new_pm == adc_seq_pkg::PM_FULL) | (new_pm == adc_seq_pkg::PM_AUTO);
    wire push = pend & fifo_ready;

    assign span_double = ~ctrl[adc_seq_pkg::RANGE_POS];
    assign coding_twos = ctrl[adc_seq_pkg::CODING_POS];
    assign waking = (wake_cnt != '0);

    // Pin synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s <= 3'h7;
            sclk_s <= 3'h7;
            din_s <= 2'h0;
        end else begin
            cs_s <= {cs_s[1:0], cs_n};
            sclk_s <= {sclk_s[1:0], sclk};
            din_s <= {din_s[0], din};
        end
    end

    // Serial framing and receive shift
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_xfer <= 1'b0;
            fall_cnt <= '0;
            rise_cnt <= '0;
            rx_sr <= '0;
        end else if (cs_fall) begin
            in_xfer <= 1'b1;
            fall_cnt <= '0;
            rise_cnt <= '0;
        end else begin
            if (cs_rise) begin
                in_xfer <= 1'b0;
            end
            if (sclk_fall && fall_cnt != adc_seq_pkg::XFER_CLKS) begin
                fall_cnt <= fall_cnt + 5'h1;
            end
            if (sclk_rise && rise_cnt != adc_seq_pkg::XFER_CLKS) begin
                rise_cnt <= rise_cnt + 5'h1;
                rx_sr <= {rx_sr[14:0], din_s[1]};
            end
        end
    end

    // Result word out, one bit per falling serial edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sr <= '0;
            cap_word <= '0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            channel_sel <= adc_seq_pkg::CH_ZERO;
        end else if (cs_fall) begin
            tx_sr <= new_word;
            cap_word <= new_word;
            channel_sel <= conv_ch;
            dout <= 1'b0;
            dout_oe <= ~(powered_down & (pm == adc_seq_pkg::PM_FULL));
        end else if (cs_rise) begin
            dout_oe <= 1'b0;
        end else if (sclk_fall) begin
            dout <= tx_sr[14];
            tx_sr <= {tx_sr[14:0], 1'b0};
            if (fall_cnt == adc_seq_pkg::LAST_SHIFT) begin
                dout_oe <= 1'b0;
            end
        end
    end

    // Track and hold, conversion start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_hold <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= cs_fall;
            if (cs_fall) begin
                sample_hold <= 1'b1;
            end else if (sclk_fall && fall_cnt == adc_seq_pkg::TRACK_FALL && !shadow_load) begin
                sample_hold <= 1'b0;
            end else if (complete) begin
                sample_hold <= go_down;
            end else if (abort) begin
                sample_hold <= powered_down;
            end
        end
    end

    // Control word, mask and sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= adc_seq_pkg::CTRL_RESET;
            mask <= adc_seq_pkg::MASK_RESET;
            ptr <= adc_seq_pkg::CH_ZERO;
            last_ch <= adc_seq_pkg::CH_ZERO;
            mode <= adc_seq_pkg::SEQ_OFF;
            shadow_load <= 1'b0;
        end else if (cs_fall) begin
            if (mode != adc_seq_pkg::SEQ_OFF) begin
                ptr <= next_ptr;
            end
        end else if (mask_wr) begin
            mask <= rx_mask;
            shadow_load <= 1'b0;
            ptr <= next_flag(rx_mask, adc_seq_pkg::CH_TOP);
            mode <= (rx_mask != '0) ? adc_seq_pkg::SEQ_MASK : adc_seq_pkg::SEQ_OFF;
        end else if (ctl_wr) begin
            ctrl <= rx_ctl;
            case (rx_sq)
                adc_seq_pkg::SQ_KEEP: begin
                    mode <= mode;
                end
                adc_seq_pkg::SQ_SHADOW: begin
                    mode <= adc_seq_pkg::SEQ_OFF;
                    shadow_load <= 1'b1;
                end
                adc_seq_pkg::SQ_CONSEC: begin
                    mode <= adc_seq_pkg::SEQ_CONSEC;
                    last_ch <= rx_addr;
                    ptr <= adc_seq_pkg::CH_ZERO;
                end
                default: begin
                    mode <= adc_seq_pkg::SEQ_OFF;
                end
            endcase
        end
    end

    // Power modes and wake interval
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            powered_down <= 1'b0;
            wake_xfer <= 1'b0;
            wake_cnt <= '0;
        end else begin
            if (cs_fall) begin
                wake_xfer <= powered_down & (pm == adc_seq_pkg::PM_FULL);
            end
            if (cs_fall && powered_down && pm == adc_seq_pkg::PM_AUTO) begin
                powered_down <= 1'b0;
                wake_cnt <= 16'(WAKE_CYC);
            end else if (complete && go_down) begin
                powered_down <= 1'b1;
                wake_cnt <= '0;
            end else if (complete && powered_down) begin
                powered_down <= 1'b0;
                wake_cnt <= 16'(WAKE_CYC);
            end else if (wake_cnt != '0) begin
                wake_cnt <= wake_cnt - 16'h1;
            end
        end
    end

    // Completed words queue toward the user side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
            pend_word <= '0;
            result_overrun <= 1'b0;
        end else begin
            result_overrun <= complete & ~wake_xfer & pend & ~push;
            if (complete && !wake_xfer && (!pend || push)) begin
                pend <= 1'b1;
                pend_word <= cap_word;
            end else if (push) begin
                pend <= 1'b0;
            end
        end
    end

    result_fifo #(
        .WIDTH(adc_seq_pkg::XFER_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(pend),
        .in_data(pend_word),
        .in_ready(fifo_ready),
        .out_valid(result_valid),
        .out_data(result_word),
        .out_ready(result_ready)
    );
endmodule : adc_seq_ctrl

//--- test/adc_seq_ctrl_asserts.sv
// Purpose: Port checker for the converter sequencer
// Assumes: Single core_clk domain, rst_n active low
// Notes: Bound to every adc_seq_ctrl instance
`timescale 1ns/1ps
module adc_seq_ctrl_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic [2:0] channel_sel,
    input wire logic sample_hold,
    input wire logic conv_start,
    input wire logic powered_down,
    input wire logic waking,
    input wire logic [15:0] result_word,
    input wire logic result_valid,
    input wire logic result_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    conv_pulse_a: assert property (conv_start |=> !conv_start) else $error("start pulse too long");
    fall_start_a: assert property ($fell(cs_n) && !powered_down |-> ##[2:6] conv_start)
        else $error("no start after select fall");
    hold_kept_a: assert property (conv_start |-> sample_hold [*8]) else $error("hold dropped early");
    lead_zero_a: assert property (conv_start && dout_oe |-> !dout) else $error("leading bit not zero");
    out_release_a: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe) else $error("output not released");
    chan_stable_a: assert property (conv_start |=> $stable(channel_sel) [*8]) else $error("channel moved");
    word_msb_a: assert property (result_valid |-> !result_word[15]) else $error("word top bit set");
    fifo_hold_a: assert property (result_valid && !result_ready |=> result_valid && $stable(result_word))
        else $error("queued word lost");
    wake_quiet_a: assert property (powered_down |-> !dout_oe) else $error("driven while shut down");
    wake_up_a: assert property (waking |-> !powered_down) else $error("waking while down");
endmodule : adc_seq_ctrl_asserts

bind adc_seq_ctrl adc_seq_ctrl_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .dout(dout),
    .dout_oe(dout_oe), .channel_sel(channel_sel), .sample_hold(sample_hold), .conv_start(conv_start),
    .powered_down(powered_down), .waking(waking), .result_word(result_word), .result_valid(result_valid),
    .result_ready(result_ready));

//--- test/serial_host_model.sv
// Purpose: Serial host driving select, clock and data
// Assumes: Clock idles high between frames, 160 ns period
// Notes: Released output line reads as the inverse of its last driven value
`timescale 1ns/1ps
module serial_host_model (
    input wire logic core_clk,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    logic last = 1'b0;
    logic oe_at_end = 1'b1;
    wire logic line = dout_oe ? dout : ~last;
    always @(posedge core_clk) if (dout_oe) last <= dout;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_clk
    // Bits go out MSB first; each result bit is taken just before a falling clock
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        wait_clk(8);
        for (int i = 0; i < n; i++) begin
            rx = {rx[14:0], line};
            sclk = 1'b0;
            din = tx[15-i];
            wait_clk(8);
            sclk = 1'b1;
            wait_clk(8);
        end
        oe_at_end = dout_oe;
        cs_n = 1'b1;
        wait_clk(500);
    endtask : xfer
endmodule : serial_host_model

//--- test/tb_adc_seq_ctrl.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Wake count shortened to 5 cycles
// Notes: Random results with fixed seed, corner cases by hand
`timescale 1ns/1ps
module tb_adc_seq_ctrl;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] adc_data = 12'h000;
    logic result_ready = 1'b1;
    wire logic cs_n, sclk, din, dout, dout_oe, sample_hold, conv_start, span_double, coding_twos;
    wire logic powered_down, waking, result_valid, result_overrun;
    wire logic [2:0] channel_sel;
    wire logic [15:0] result_word;
    int fails = 0;
    int total_checks = 0;
    int ovr = 0;
    int oe_seen = 0;
    int wake_seen = 0;
    logic twos = 1'b0;
    logic [15:0] got[$];
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (result_valid === 1'b1 && result_ready) got.push_back(result_word);
        if (result_overrun === 1'b1) ovr++;
        if (dout_oe === 1'b1) oe_seen++;
        if (waking === 1'b1) wake_seen++;
    end
    adc_seq_ctrl #(.WAKE_CYC(5), .DEPTH(4)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .din(din), .adc_data(adc_data), .dout(dout), .dout_oe(dout_oe), .channel_sel(channel_sel),
        .sample_hold(sample_hold), .conv_start(conv_start), .span_double(span_double), .coding_twos(coding_twos),
        .powered_down(powered_down), .waking(waking), .result_word(result_word), .result_valid(result_valid),
        .result_ready(result_ready), .result_overrun(result_overrun));
    serial_host_model u_host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [15:0] ctl(input int w, input int sq, input logic [2:0] a, input logic [1:0] pm,
        input int sh, input int rg, input int cd);
        return {1'(w), 1'(sq), a, pm, 1'(sh), 2'b00, 1'(rg), 1'(cd), 4'h0};
    endfunction : ctl
    function automatic logic [2:0] next_flag(input logic [7:0] m, input logic [2:0] c);
        logic [2:0] n = c;
        for (int i = 0; i < 8; i++) begin
            n = n + 3'h1;
            if (m[n]) return n;
        end
        return c;
    endfunction : next_flag
    // One full transfer converting channel ch; control effects land after it
    task automatic conv(input logic [15:0] tx, input logic [2:0] ch);
        logic [15:0] rx;
        logic [15:0] exp;
        adc_data = 12'($urandom);
        exp = {1'b0, ch, twos ? adc_data ^ 12'h800 : adc_data};
        u_host.xfer(tx, 16, rx);
        check("serial word", exp, rx);
        check("released", 16'h0000, {15'h0, u_host.oe_at_end});
        check("queued word", exp, got.size() > 0 ? got.pop_front() : 16'hxxxx);
        if (tx[15]) begin
            twos = tx[4];
            check("coding", {15'h0, twos}, {15'h0, coding_twos});
            check("span", {15'h0, ~tx[5]}, {15'h0, span_double});
        end
    endtask : conv
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #600000;
        fails++;
        give_verdict();
    end
    initial begin
        logic [15:0] rx;
        logic [7:0] m;
        logic [2:0] cur;
        logic [15:0] qw;
        void'($urandom(32'hd8d6e887));
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        u_host.wait_clk(4);
        for (int c = 1; c <= 8; c++) conv(ctl(1, 0, 3'(c), 2'h3, 0, 1'($urandom), 1'($urandom)), 3'(c - 1));
        conv(16'h7ff0, 3'h0);
        conv(ctl(1, 0, 3'h5, 2'h3, 1, 0, 0), 3'h0);
        $display("test direct done");
        m = 8'($urandom) | 8'h80;
        u_host.xfer({8'h00, m}, 16, rx);
        got.delete();
        cur = 3'h7;
        for (int k = 0; k < 12; k++) begin
            cur = next_flag(m, cur);
            conv(k == 5 ? ctl(1, 1, 3'h2, 2'h3, 0, 0, 0) : 16'h0000, cur);
        end
        conv(ctl(1, 0, 3'h6, 2'h3, 0, 0, 0), next_flag(m, cur));
        conv(ctl(1, 1, 3'h3, 2'h3, 1, 0, 0), 3'h6);
        $display("test mask done");
        for (int k = 0; k < 9; k++) conv(16'h0000, 3'(k % 4));
        conv(ctl(1, 0, 3'h1, 2'h3, 0, 0, 0), 3'h1);
        u_host.xfer(ctl(1, 0, 3'h4, 2'h3, 0, 1, 1), 8, rx);
        check("abort queue", 16'h0000, 16'(got.size()));
        conv(16'h0000, 3'h1);
        $display("test consecutive done");
        result_ready = 1'b0;
        for (int k = 0; k < 6; k++) u_host.xfer(16'h0000, 16, rx);
        check("overrun", 16'h0001, 16'(ovr));
        result_ready = 1'b1;
        u_host.wait_clk(10);
        check("drained", 16'h0005, 16'(got.size()));
        while (got.size() > 0) begin
            qw = got.pop_front();
            check("drained channel", 16'h1, {13'h0, qw[14:12]});
        end
        check("empty", 16'h0000, {15'h0, result_valid});
        $display("test buffer done");
        conv(ctl(1, 0, 3'h2, 2'h2, 0, 0, 0), 3'h1);
        check("full down", 16'h0001, {15'h0, powered_down});
        oe_seen = 0;
        wake_seen = 0;
        u_host.xfer(ctl(1, 0, 3'h2, 2'h3, 0, 0, 0), 16, rx);
        check("wake undriven", 16'h0000, 16'(oe_seen));
        check("wake queue", 16'h0000, 16'(got.size()));
        check("woken", 16'h0000, {15'h0, powered_down});
        check("wake span", 16'h0005, 16'(wake_seen));
        conv(16'h0000, 3'h2);
        conv(ctl(1, 0, 3'h2, 2'h1, 0, 0, 0), 3'h2);
        check("auto down", 16'h0001, {15'h0, powered_down});
        wake_seen = 0;
        conv(ctl(1, 0, 3'h2, 2'h3, 0, 0, 0), 3'h2);
        check("auto wake span", 16'h0005, 16'(wake_seen));
        check("normal up", 16'h0000, {15'h0, powered_down});
        $display("test power done");
        give_verdict();
    end
endmodule : tb_adc_seq_ctrl
